// file: hdl/hbd_pkg.sv
package hbd_pkg;

    // Clock rate used to turn times into cycle counts.
    localparam int unsigned CLK_HZ = 100_000_000;

    // Dead time between releasing a high-side command and turning on a low switch.
    localparam int unsigned DEAD_TIME_NS = 1000;
    localparam int unsigned DEAD_CYCLES = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Blanking delay that tolerates inrush current.
    localparam int unsigned BLANK_TIME_US = 3000;
    localparam int unsigned BLANK_CYCLES = BLANK_TIME_US * (CLK_HZ / 1_000_000);

    // Fast limit for a severe short circuit.
    localparam int unsigned FAST_LIMIT_US = 20;
    localparam int unsigned FAST_CYCLES = FAST_LIMIT_US * (CLK_HZ / 1_000_000);

    // Retry interval after a trip.
    localparam int unsigned RETRY_TIME_MS = 1800;
    localparam int unsigned RETRY_CYCLES = RETRY_TIME_MS * (CLK_HZ / 1000);

    // Two-cycle severe short filter length, well inside the fast limit; no module uses it, and the channel trips on one synchronised sample.
    localparam int unsigned SEVERE_CYCLES = 2;

    // Switch drive bundle.
    typedef struct packed {
        logic left_high_switch;
        logic right_high_switch;
        logic left_low_switch;
        logic right_low_switch;
    } hbd_drive_t;

    // Per-channel sense inputs after synchronising.
    typedef struct packed {
        logic overcurrent;
        logic severe;
    } hbd_sense_t;

endpackage

// file: hdl/hbd_channel.sv
// One high-side protection channel: blanking, trip clamp and retry timer.
module hbd_channel #(
    parameter int unsigned BLANK_CYCLES = hbd_pkg::BLANK_CYCLES,
    parameter int unsigned RETRY_CYCLES = hbd_pkg::RETRY_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_in,
    input wire hbd_pkg::hbd_sense_t sense_in,
    output logic clamp_out,
    output logic trip_out
);

    localparam int BW = $clog2(BLANK_CYCLES + 1);
    localparam int RW = $clog2(RETRY_CYCLES + 1);
    localparam logic [BW-1:0] BLANK_END = BW'(BLANK_CYCLES);
    localparam logic [RW-1:0] RETRY_END = RW'(RETRY_CYCLES);

    logic [BW-1:0] blank_cnt;
    logic [BW-1:0] next_blank_cnt;
    logic [RW-1:0] retry_cnt;
    logic [RW-1:0] next_retry_cnt;
    logic clamp;
    logic next_clamp;
    logic trip;

    assign clamp_out = clamp;
    assign trip_out = trip;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the blanking counter, clamp and retry timer.
    always_comb begin
        next_blank_cnt = blank_cnt;
        next_retry_cnt = retry_cnt;
        next_clamp = clamp;
        trip = 1'b0;
        if (!cmd_in || clamp) begin
            next_blank_cnt = '0;
        end else if (blank_cnt != BLANK_END) begin
            next_blank_cnt = blank_cnt + BW'(1);
        end
        if (cmd_in && (sense_in.severe || (sense_in.overcurrent && blank_cnt == BLANK_END))) begin
            trip = 1'b1;
        end
        if (trip) begin
            next_clamp = 1'b1;
            next_retry_cnt = '0;
        end else if (clamp) begin
            if (retry_cnt == RETRY_END) begin
                next_clamp = 1'b0;
                next_retry_cnt = '0;
            end else begin
                next_retry_cnt = retry_cnt + RW'(1);
            end
        end
    end

    // Register the channel state; reset clears every counter.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            blank_cnt <= '0;
            retry_cnt <= '0;
            clamp <= 1'b0;
        end else begin
            blank_cnt <= next_blank_cnt;
            retry_cnt <= next_retry_cnt;
            clamp <= next_clamp;
        end
    end

endmodule

// file: hdl/hbd_ctrl.sv
// How it works
// - First input high, second low: left high and right low switches on.
// - Second input high, first low: right high and left low switches on.
// - Both inputs low: high switches off, both low switches on to brake.
// - Both inputs high: all four switches off, motor coasts.
// - Low switch turns on only after dead time following high release.
// - Trip forces that gate low, stops charge pump, restarts retry timer.
// - Gate stays clamped until retry timer ends, then pump and drive resume.
// - Shutdown and retry repeat while overcurrent persists; a held severe short keeps the gate clamped; no effect once cleared.
// - A fault clamps only its own high switch; the other channel continues.
// - Ordinary overcurrent is blanked; severe short trips within the fast limit.
// - Retry interval is a parameter.
module hbd_ctrl #(
    parameter int unsigned DEAD_CYCLES = hbd_pkg::DEAD_CYCLES,
    parameter int unsigned BLANK_CYCLES = hbd_pkg::BLANK_CYCLES,
    parameter int unsigned RETRY_CYCLES = hbd_pkg::RETRY_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic high_cmd_a_in,
    input wire logic high_cmd_b_in,
    input wire logic overcurrent_in_a,
    input wire logic overcurrent_in_b,
    input wire logic severe_in_a,
    input wire logic severe_in_b,
    output hbd_pkg::hbd_drive_t drive_out,
    output logic high_drive_a_out,
    output logic high_drive_b_out,
    output logic pump_en_a_out,
    output logic pump_en_b_out,
    output logic fault_a_out,
    output logic fault_b_out
);

    localparam int DW = $clog2(DEAD_CYCLES + 1);
    localparam logic [DW-1:0] DEAD_END = DW'(DEAD_CYCLES);

    // Two-stage synchronisers for all pin inputs: bit order cmd_a, cmd_b, oc_a, oc_b, sv_a, sv_b.
    logic [5:0] sync_meta;
    logic [5:0] sync_q;
    logic [5:0] pins;
    logic dir_a;
    logic dir_b;
    hbd_pkg::hbd_sense_t sense_a;
    hbd_pkg::hbd_sense_t sense_b;
    logic [1:0] clamp;
    logic [1:0] trip;

    logic want_lh;
    logic want_rh;
    logic want_ll;
    logic want_rl;
    logic [DW-1:0] dead_l;
    logic [DW-1:0] next_dead_l;
    logic [DW-1:0] dead_r;
    logic [DW-1:0] next_dead_r;
    hbd_pkg::hbd_drive_t drive;
    hbd_pkg::hbd_drive_t next_drive;
    logic [1:0] pump;
    logic [1:0] next_pump;
    logic [1:0] fault;

    assign pins = {high_cmd_a_in, high_cmd_b_in, overcurrent_in_a, overcurrent_in_b, severe_in_a, severe_in_b};
    assign dir_a = sync_q[5];
    assign dir_b = sync_q[4];
    assign sense_a = '{overcurrent: sync_q[3], severe: sync_q[1]};
    assign sense_b = '{overcurrent: sync_q[2], severe: sync_q[0]};

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser; only the second stage feeds logic.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync_meta <= '0;
            sync_q <= '0;
        end else begin
            sync_meta <= pins;
            sync_q <= sync_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Independent protection per channel.
    hbd_channel #(
        .BLANK_CYCLES(BLANK_CYCLES),
        .RETRY_CYCLES(RETRY_CYCLES)
    ) u_chan_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cmd_in(want_lh),
        .sense_in(sense_a),
        .clamp_out(clamp[0]),
        .trip_out(trip[0])
    );

    hbd_channel #(
        .BLANK_CYCLES(BLANK_CYCLES),
        .RETRY_CYCLES(RETRY_CYCLES)
    ) u_chan_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cmd_in(want_rh),
        .sense_in(sense_b),
        .clamp_out(clamp[1]),
        .trip_out(trip[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode the direction pair into the wanted switch pattern.
    always_comb begin
        want_lh = dir_a && !dir_b;
        want_rl = dir_a && !dir_b;
        want_rh = dir_b && !dir_a;
        want_ll = dir_b && !dir_a;
        if (!dir_a && !dir_b) begin
            want_ll = 1'b1;
            want_rl = 1'b1;
        end
        // Both high leaves everything off by the terms above.
    end

    ////////////////////////////////////////////////////////////////////////
    // Dead-time counters and final drive, with fault clamps applied.
    always_comb begin
        next_dead_l = dead_l;
        next_dead_r = dead_r;
        if (drive.left_high_switch) begin
            next_dead_l = '0;
        end else if (dead_l != DEAD_END) begin
            next_dead_l = dead_l + DW'(1);
        end
        if (drive.right_high_switch) begin
            next_dead_r = '0;
        end else if (dead_r != DEAD_END) begin
            next_dead_r = dead_r + DW'(1);
        end
        next_drive.left_high_switch = want_lh && !clamp[0] && !trip[0] && !drive.left_low_switch;
        next_drive.right_high_switch = want_rh && !clamp[1] && !trip[1] && !drive.right_low_switch;
        next_drive.left_low_switch = want_ll && !drive.left_high_switch && dead_l == DEAD_END;
        next_drive.right_low_switch = want_rl && !drive.right_high_switch && dead_r == DEAD_END;
        next_pump[0] = !clamp[0] && !trip[0];
        next_pump[1] = !clamp[1] && !trip[1];
    end

    // Register drive and timers; reset holds all switches off.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dead_l <= '0;
            dead_r <= '0;
            drive <= '0;
            pump <= '0;
            fault <= '0;
        end else begin
            dead_l <= next_dead_l;
            dead_r <= next_dead_r;
            drive <= next_drive;
            pump <= next_pump;
            fault <= clamp | trip;
        end
    end

    // Outputs come straight from registers.
    assign drive_out = drive;
    assign high_drive_a_out = drive.left_high_switch;
    assign high_drive_b_out = drive.right_high_switch;
    assign pump_en_a_out = pump[0];
    assign pump_en_b_out = pump[1];
    assign fault_a_out = fault[0];
    assign fault_b_out = fault[1];

endmodule

// file: verif/hbd_host.sv
module hbd_host (
    input wire logic clk_in,
    input wire logic [1:0] mode_in,
    input wire logic slow_in,
    output logic high_cmd_a_out,
    output logic high_cmd_b_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pins = 2'h0;
    // A slow host parks in coast for one cycle before a new code.
    always @(posedge clk_in) begin
        pins <= (slow_in && mode_in != pins && pins != 2'h3) ? 2'h3 : mode_in;
    end
    assign high_cmd_a_out = pins[1];
    assign high_cmd_b_out = pins[0];
endmodule

// file: verif/hbd_chk_sva.sv
module hbd_chk #(parameter int unsigned RETRY_CYCLES = 50) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic high_cmd_a_in,
    input wire logic high_cmd_b_in,
    input wire logic severe_in_a,
    input wire hbd_pkg::hbd_drive_t drive_out,
    input wire logic high_drive_a_out,
    input wire logic pump_en_a_out,
    input wire logic pump_en_b_out,
    input wire logic fault_a_out,
    input wire logic fault_b_out
);
    localparam int RLO = RETRY_CYCLES - 5;
    logic [7:0] hist;
    logic [7:0] next_hist;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Keeps both high switches of the last four cycles.
    always_comb next_hist = {hist[5:0], drive_out.left_high_switch, drive_out.right_high_switch};
    always_ff @(posedge clk_in) hist <= next_hist;
    // The clamp holds the pump off for most of the retry interval.
    sequence s_clamp; !pump_en_a_out throughout ##RLO 1; endsequence
    // A pin level reaches the drive three edges after it is sampled: two sync stages and the drive register.
    property p_fwd; drive_out.left_high_switch |-> $past(high_cmd_a_in, 3) && !$past(high_cmd_b_in, 3); endproperty
    a_fwd: assert property (p_fwd) else $error("left high without forward");
    property p_rev; drive_out.right_high_switch |-> $past(high_cmd_b_in, 3) && !$past(high_cmd_a_in, 3); endproperty
    a_rev: assert property (p_rev) else $error("right high without reverse");
    property p_brake; (!high_cmd_a_in && !high_cmd_b_in) [*8] |=> ##1 drive_out == 4'h3; endproperty
    a_brake: assert property (p_brake) else $error("no brake");
    property p_coast; (high_cmd_a_in && high_cmd_b_in) [*4] |=> drive_out == 4'h0; endproperty
    a_coast: assert property (p_coast) else $error("no coast");
    property p_dead; $rose(drive_out.left_low_switch) |-> {hist[7], hist[5], hist[3], hist[1]} == 4'h0; endproperty
    a_dead: assert property (p_dead) else $error("dead time short");
    property p_trip; $rose(fault_a_out) |-> !pump_en_a_out && !drive_out.left_high_switch; endproperty
    a_trip: assert property (p_trip) else $error("trip left drive on");
    property p_retry; $rose(fault_a_out) |-> s_clamp ##[1:12] pump_en_a_out; endproperty
    a_retry: assert property (p_retry) else $error("retry length wrong");
    property p_indep; fault_a_out && !fault_b_out |-> pump_en_b_out; endproperty
    a_indep: assert property (p_indep) else $error("other channel hit");
    property p_fast; severe_in_a [*2] |-> ##[1:6] !high_drive_a_out; endproperty
    a_fast: assert property (p_fast) else $error("severe trip slow");
    property p_reset; @(posedge clk_in) disable iff (1'b0) rst_in |=> drive_out == 4'h0 && !pump_en_a_out; endproperty
    a_reset: assert property (p_reset) else $error("reset left a switch on");
endmodule
bind hbd_ctrl hbd_chk #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .high_cmd_a_in(high_cmd_a_in), .high_cmd_b_in(high_cmd_b_in),
    .severe_in_a(severe_in_a), .drive_out(drive_out), .high_drive_a_out(high_drive_a_out),
    .pump_en_a_out(pump_en_a_out), .pump_en_b_out(pump_en_b_out), .fault_a_out(fault_a_out),
    .fault_b_out(fault_b_out));

// file: verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLANK = 20;
    localparam int RETRY = 50;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] mode = 2'h0;
    logic slow = 1'b0;
    logic oc_a = 1'b0;
    logic oc_b = 1'b0;
    logic sev_a = 1'b0;
    logic sev_b = 1'b0;
    logic cmd_a;
    logic cmd_b;
    hbd_pkg::hbd_drive_t drive;
    logic hda;
    logic hdb;
    logic pa;
    logic pb;
    logic fa;
    logic fb;
    int miscompares = 0;
    int compares = 0;
    int n;
    // System clock.
    always #5 clk_in = ~clk_in;
    hbd_host host (.clk_in(clk_in), .mode_in(mode), .slow_in(slow), .high_cmd_a_out(cmd_a), .high_cmd_b_out(cmd_b));
    hbd_ctrl #(.DEAD_CYCLES(4), .BLANK_CYCLES(BLANK), .RETRY_CYCLES(RETRY)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .high_cmd_a_in(cmd_a), .high_cmd_b_in(cmd_b),
        .overcurrent_in_a(oc_a), .overcurrent_in_b(oc_b), .severe_in_a(sev_a), .severe_in_b(sev_b),
        .drive_out(drive), .high_drive_a_out(hda), .high_drive_b_out(hdb), .pump_en_a_out(pa),
        .pump_en_b_out(pb), .fault_a_out(fa), .fault_b_out(fb));
    // Switch pattern for a host code {a, b}, left high first.
    function automatic logic [3:0] pattern(int code);
        int pat[$] = {3, 6, 9, 0};
        return pat[code][3:0];
    endfunction
    // Full output state: switches, high copies, then pumps and faults.
    function automatic logic [9:0] st(logic [3:0] d, logic [3:0] f);
        return {d, d[3:2], f};
    endfunction
    // Prints the verdict and stops.
    task automatic conclude();
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares the whole output state.
    task automatic chk(logic [9:0] e);
        compares++;
        if ({drive, hda, hdb, pa, pb, fa, fb} !== e) begin
            miscompares++;
            $display("mismatch %0t exp %h got %h", $time, e, {drive, hda, hdb, pa, pb, fa, fb});
        end
    endtask
    // Compares a duration or a bound held by the bench.
    task automatic chk_n(int e, int g);
        compares++;
        if (g != e) begin
            miscompares++;
            $display("mismatch %0t exp %h got %h", $time, e, g);
        end
    endtask
    // Counts cycles until a flag reaches a level, giving up after a bound.
    task automatic wait_lvl(ref logic s, input logic v, output int k);
        for (k = 0; s !== v; k++) begin
            @(negedge clk_in);
            if (k > 400) begin
                miscompares++;
                conclude();
            end
        end
    endtask
    // Sets a host code and lets it settle.
    task automatic go(logic [1:0] m, logic s);
        @(posedge clk_in);
        mode <= m;
        slow <= s;
        repeat (14) @(negedge clk_in);
    endtask
    // Main sequence.
    initial begin
        void'($urandom(91));
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        chk(st(4'h0, 4'h0));
        @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            go(i < 4 ? 2'(i) : 2'($urandom_range(3)), i[0]);
            chk(st(pattern(mode), 4'hc));
        end
        go(2'h1, 1'b0);
        go(2'h2, 1'b0);
        chk(st(4'h9, 4'hc));
        @(posedge clk_in);
        sev_a <= 1'b1;
        repeat (2) @(posedge clk_in);
        sev_a <= 1'b0;
        wait_lvl(pa, 1'b0, n);
        chk(st(4'h1, 4'h6));
        chk_n(1, int'(n < 6));
        wait_lvl(pa, 1'b1, n);
        chk_n(1, int'(n >= RETRY && n <= RETRY + 4));
        repeat (3) @(negedge clk_in);
        chk(st(4'h9, 4'hc));
        go(2'h1, 1'b0);
        @(posedge clk_in);
        oc_a <= 1'b1;
        go(2'h1, 1'b0);
        chk(st(4'h6, 4'hc));
        go(2'h2, 1'b0);
        chk(st(4'h9, 4'hc));
        @(posedge clk_in);
        oc_b <= 1'b1;
        wait_lvl(pa, 1'b0, n);
        chk_n(1, int'(n + 15 >= BLANK && n + 15 <= BLANK + 12));
        wait_lvl(pa, 1'b1, n);
        wait_lvl(pa, 1'b0, n);
        chk_n(1, int'(n >= BLANK && n <= BLANK + 12));
        @(posedge clk_in);
        oc_a <= 1'b0;
        wait_lvl(pa, 1'b1, n);
        repeat (BLANK + 10) @(negedge clk_in);
        chk(st(4'h9, 4'hc));
        // Severe short on the right channel in reverse, before its blanking ends.
        go(2'h1, 1'b0);
        chk(st(4'h6, 4'hc));
        @(posedge clk_in);
        oc_b <= 1'b0;
        sev_b <= 1'b1;
        repeat (2) @(posedge clk_in);
        sev_b <= 1'b0;
        wait_lvl(pb, 1'b0, n);
        chk(st(4'h2, 4'h9));
        chk_n(1, int'(n < 6));
        wait_lvl(pb, 1'b1, n);
        chk_n(1, int'(n >= RETRY && n <= RETRY + 4));
        repeat (3) @(negedge clk_in);
        chk(st(4'h6, 4'hc));
        conclude();
    end
endmodule
